// file: rtl/lcms_mode_select.v
/*
  Per-frame concealment mode selector for an audio frame decoder.
  Assumes the frame decoder presents loss flags and frame statistics
  together with a one-cycle frameStrobe, on the same clock.
*/
`timescale 1ns/1ps
`include "lcms_defs.vh"

module lcms_mode_select #(
  parameter NUM_BANDS = 16,
  parameter NORM_W    = 8
) (
  input  wire                        clock,
  input  wire                        resetn,
  input  wire                        frameStrobe,
  input  wire                        badFrame,
  input  wire                        frameFreqMode,
  input  wire [`LCMS_EW-1:0]         diffEnergy,
  input  wire                        transientFrame,
  input  wire [NUM_BANDS*NORM_W-1:0] bandNorms,
  output wire                        modeValid,
  output wire [`LCMS_MW-1:0]         concealMode,
  output wire [`LCMS_KW-1:0]         frameClass,
  output wire [`LCMS_CW-1:0]         lostFrameCount,
  output wire                        prevBad,
  output wire                        alignAllowed,
  output wire                        alignContinue,
  output wire                        steadyOut,
  output wire                        fdConceal,
  output wire                        spectrumRepeat,
  output wire                        overlapAddPrev
);

  localparam IDX_W = 4;

  reg                  valid_ff;
  reg [`LCMS_MW-1:0]   mode_ff;
  reg [`LCMS_MW-1:0]   nxt_mode;
  reg [`LCMS_KW-1:0]   class_ff;
  reg [`LCMS_KW-1:0]   nxt_class;
  reg [`LCMS_CW-1:0]   count_ff;
  reg [`LCMS_CW-1:0]   nxt_count;
  reg                  prevBad_ff;
  reg                  prevFd_ff;
  reg                  allowed_ff;
  reg                  nxt_allowed;
  reg                  continue_ff;
  reg                  nxt_continue;
  reg                  statOld_ff;
  reg                  statOut_ff;
  reg                  fd_ff;
  reg                  ola_ff;
  reg [IDX_W-1:0]      prevPeak_ff;
  reg [2:0]            trans_ff;
  wire [IDX_W-1:0]     peakIdx;
  wire                 peakLow;
  wire                 statCurr;
  wire                 statNext;
  wire                 steadyNow;
  wire                 peakNear;

  // ----------------------------------------------------------------------
  // Sub-band peak search
  // ----------------------------------------------------------------------
  lcms_peak_band #(
    .NUM_BANDS (NUM_BANDS),
    .NORM_W    (NORM_W),
    .IDX_W     (IDX_W)
  ) u_peak (
    .bandNorms (bandNorms),
    .peakIdx   (peakIdx),
    .peakLow   (peakLow)
  );

  // Stationarity with hysteresis; the selector sees this frame's output
  assign statCurr  = (diffEnergy < `LCMS_THR_STEADY);
  assign statNext  = (statOld_ff == statCurr) ? statCurr : statOut_ff;
  assign steadyNow = statNext || (diffEnergy < `LCMS_THR_SMOOTH);
  assign peakNear  = (peakIdx >= prevPeak_ff) ? (peakIdx - prevPeak_ff <= 4'h1)
                                              : (prevPeak_ff - peakIdx <= 4'h1);

  // ----------------------------------------------------------------------
  // Lost-frame count: restarts at one on the first loss after a good frame
  // ----------------------------------------------------------------------
  always @* begin
    if (badFrame) begin
      if (!prevBad_ff)
        nxt_count = 8'h01;
      else if (count_ff == 8'hff)
        nxt_count = count_ff;   // Saturate rather than wrap to a false single loss
      else
        nxt_count = count_ff + 8'h01;
    end else begin
      nxt_count = prevBad_ff ? count_ff : 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Frame class
  // ----------------------------------------------------------------------
  always @* begin
    if (badFrame)
      nxt_class = (nxt_count == 8'h01) ? `LCMS_K_SINGLE : `LCMS_K_BURST;
    else if (prevBad_ff)
      nxt_class = (nxt_count > 8'h01) ? `LCMS_K_GOOD_AB : `LCMS_K_GOOD_AS;
    else
      nxt_class = `LCMS_K_GOOD;
  end

  // ----------------------------------------------------------------------
  // Mode selection; phase-alignment tests come first, in fixed priority
  // ----------------------------------------------------------------------
  always @* begin
    nxt_mode     = `LCMS_M_NORMAL;
    nxt_continue = continue_ff;
    if (badFrame && nxt_count == 8'h01 && allowed_ff && !continue_ff) begin
      nxt_mode     = `LCMS_M_PM_LOST;
      nxt_continue = 1'h1;
    end else if (prevBad_ff && !badFrame && continue_ff) begin
      nxt_mode     = `LCMS_M_PM_NEXT;
      nxt_continue = 1'h0;      // The chain of aligned frames ends here
    end else if (prevBad_ff && badFrame && continue_ff) begin
      nxt_mode     = `LCMS_M_PM_BURST;
    end else if (badFrame) begin
      nxt_continue = 1'h0;
      nxt_mode     = steadyNow ? `LCMS_M_RS_LOST : `LCMS_M_OLA;
    end else if (prevBad_ff) begin
      nxt_continue = 1'h0;
      if (steadyNow)
        nxt_mode = `LCMS_M_RS_NEXT;
      else if (nxt_count > 8'h01)
        nxt_mode = `LCMS_M_AFT_BURST;
      else
        nxt_mode = `LCMS_M_OLA;
    end
  end

  // ----------------------------------------------------------------------
  // Alignment-allowed flag, refreshed only in the memory update of good frames
  // ----------------------------------------------------------------------
  always @* begin
    if (badFrame)
      nxt_allowed = allowed_ff;
    else
      nxt_allowed = peakLow && peakNear && statCurr && (trans_ff == 3'h0);
  end

  // ----------------------------------------------------------------------
  // Frame-boundary registers
  // ----------------------------------------------------------------------
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      valid_ff    <= 1'h0;
      mode_ff     <= `LCMS_M_NORMAL;
      class_ff    <= `LCMS_K_GOOD;
      count_ff    <= 8'h00;
      prevBad_ff  <= 1'h0;
      prevFd_ff   <= 1'h0;
      allowed_ff  <= 1'h0;
      continue_ff <= 1'h0;
      statOld_ff  <= 1'h0;
      statOut_ff  <= 1'h0;
      fd_ff       <= 1'h0;
      ola_ff      <= 1'h0;
      prevPeak_ff <= 4'h0;
      trans_ff    <= 3'h0;
    end else begin
      valid_ff <= frameStrobe;
      if (frameStrobe) begin
        mode_ff     <= nxt_mode;
        class_ff    <= nxt_class;
        count_ff    <= nxt_count;
        prevBad_ff  <= badFrame;
        continue_ff <= nxt_continue;
        allowed_ff  <= nxt_allowed;
        statOut_ff  <= statNext;
        statOld_ff  <= statCurr;
        fd_ff       <= badFrame && prevFd_ff;
        ola_ff      <= (nxt_mode == `LCMS_M_OLA);
        // A lost frame keeps the coding mode of the last decoded frame
        if (!badFrame) begin
          prevFd_ff   <= frameFreqMode;
          prevPeak_ff <= peakIdx;
          trans_ff    <= {trans_ff[1:0], transientFrame};
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------------------------------------
  assign modeValid      = valid_ff;
  assign concealMode    = mode_ff;
  assign frameClass     = class_ff;
  assign lostFrameCount = count_ff;
  assign prevBad        = prevBad_ff;
  assign alignAllowed   = allowed_ff;
  assign alignContinue  = continue_ff;
  assign steadyOut      = statOut_ff;
  assign fdConceal      = fd_ff;        // Frequency-domain path enable
  assign spectrumRepeat = fd_ff;
  assign overlapAddPrev = ola_ff;

endmodule // lcms_mode_select

// file: rtl/lcms_defs.vh
/*
  Constants for the loss concealment mode selector: widths, thresholds,
  one-hot mode and frame-class codes, low-band limits.
  Assumes energy figures arrive as unsigned Q0.16 fractions.
*/
`ifndef LCMS_DEFS_VH
`define LCMS_DEFS_VH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define LCMS_EW          16
`define LCMS_CW          8
`define LCMS_MW          8
`define LCMS_KW          5

// ----------------------------------------------------------------------
// Thresholds, Q0.16 (0.159063 and 0.032209 scaled by 65536)
// ----------------------------------------------------------------------
`define LCMS_THR_SMOOTH  16'h28b8
`define LCMS_THR_STEADY  16'h083f

// ----------------------------------------------------------------------
// Low band 75 Hz .. 1000 Hz expressed as sub-band indices
// ----------------------------------------------------------------------
`define LCMS_LOW_FIRST   4'h1
`define LCMS_LOW_LAST    4'h4

// ----------------------------------------------------------------------
// Concealment modes, one-hot
// ----------------------------------------------------------------------
`define LCMS_M_NORMAL    8'h01
`define LCMS_M_PM_LOST   8'h02
`define LCMS_M_PM_NEXT   8'h04
`define LCMS_M_PM_BURST  8'h08
`define LCMS_M_RS_LOST   8'h10
`define LCMS_M_RS_NEXT   8'h20
`define LCMS_M_AFT_BURST 8'h40
`define LCMS_M_OLA       8'h80

// ----------------------------------------------------------------------
// Frame classes, one-hot
// ----------------------------------------------------------------------
`define LCMS_K_GOOD      5'h01
`define LCMS_K_SINGLE    5'h02
`define LCMS_K_BURST     5'h04
`define LCMS_K_GOOD_AS   5'h08
`define LCMS_K_GOOD_AB   5'h10

`endif

// file: rtl/lcms_peak_band.v
/*
  Finds the sub-band with the highest energy, energy being the square
  of each band's norm, and tells whether it lies in the low band.
  Assumes norms are stable while the frame strobe is high.
*/
`timescale 1ns/1ps
`include "lcms_defs.vh"

module lcms_peak_band #(
  parameter NUM_BANDS = 16,
  parameter NORM_W    = 8,
  parameter IDX_W     = 4
) (
  input  wire [NUM_BANDS*NORM_W-1:0] bandNorms,
  output reg  [IDX_W-1:0]            peakIdx,
  output wire                        peakLow
);

  reg [2*NORM_W-1:0] bestEnergy;
  reg [2*NORM_W-1:0] thisEnergy;
  reg [NORM_W-1:0]   thisNorm;
  integer            i;

  // ----------------------------------------------------------------------
  // Peak search; first band wins a tie so the result is deterministic
  // ----------------------------------------------------------------------
  always @* begin
    bestEnergy = {(2*NORM_W){1'h0}};
    thisEnergy = {(2*NORM_W){1'h0}};
    thisNorm   = {NORM_W{1'h0}};
    peakIdx    = {IDX_W{1'h0}};
    for (i = 0; i < NUM_BANDS; i = i + 1) begin
      thisNorm   = bandNorms[i*NORM_W +: NORM_W];
      thisEnergy = thisNorm * thisNorm;
      if (thisEnergy > bestEnergy) begin
        bestEnergy = thisEnergy;
        peakIdx    = i[IDX_W-1:0];
      end
    end
  end

  // Low band limits
  assign peakLow = (peakIdx >= `LCMS_LOW_FIRST) && (peakIdx <= `LCMS_LOW_LAST);

endmodule // lcms_peak_band

// file: testbench/lcms_monitor.sv
/*
  Checker for the concealment mode selector, bound to its ports.
  Assumes one clock domain and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`include "lcms_defs.vh"

module lcms_monitor (
  input wire                clock,
  input wire                resetn,
  input wire                frameStrobe,
  input wire                badFrame,
  input wire [`LCMS_EW-1:0] diffEnergy,
  input wire                modeValid,
  input wire [`LCMS_MW-1:0] concealMode,
  input wire [`LCMS_KW-1:0] frameClass,
  input wire [`LCMS_CW-1:0] lostFrameCount,
  input wire                prevBad,
  input wire                alignAllowed,
  input wire                alignContinue,
  input wire                steadyOut,
  input wire                fdConceal,
  input wire                spectrumRepeat,
  input wire                overlapAddPrev
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // ----------------------------------------------------------------
  // Decision timing and state
  // ----------------------------------------------------------------
  property p_valid; frameStrobe |=> modeValid; endproperty
  a_valid: assert property (p_valid) else $error("no answer after strobe");
  // A frame without strobe must leave the concealment mode and the lost-frame count untouched
  property p_hold; !frameStrobe |=> $stable(concealMode) && $stable(lostFrameCount); endproperty
  a_hold: assert property (p_hold) else $error("state moved without strobe");
  property p_one; frameStrobe && badFrame && !prevBad |=> lostFrameCount == 8'h01; endproperty
  a_one: assert property (p_one) else $error("first loss count wrong");
  property p_fd; fdConceal |-> prevBad && spectrumRepeat; endproperty
  a_fd: assert property (p_fd) else $error("spectral path on good frame");
  property p_ola; overlapAddPrev == (concealMode == `LCMS_M_OLA); endproperty
  a_ola: assert property (p_ola) else $error("overlap flag disagrees");
  // ----------------------------------------------------------------
  // Mode priority
  // ----------------------------------------------------------------
  property p_pml;
    frameStrobe && badFrame && !prevBad && alignAllowed && !alignContinue
      |=> concealMode == `LCMS_M_PM_LOST && alignContinue;
  endproperty
  a_pml: assert property (p_pml) else $error("aligned loss mode missed");
  property p_pmn;
    frameStrobe && prevBad && !badFrame && alignContinue
      |=> concealMode == `LCMS_M_PM_NEXT && !alignContinue;
  endproperty
  a_pmn: assert property (p_pmn) else $error("aligned next mode missed");
  property p_pmb; frameStrobe && prevBad && badFrame && alignContinue
    |=> concealMode == `LCMS_M_PM_BURST && frameClass == `LCMS_K_BURST; endproperty
  a_pmb: assert property (p_pmb) else $error("aligned burst mode missed");
  property p_rs; frameStrobe && badFrame && !alignContinue && (prevBad || !alignAllowed)
    && diffEnergy < `LCMS_THR_SMOOTH |=> concealMode == `LCMS_M_RS_LOST; endproperty
  a_rs: assert property (p_rs) else $error("smoothing mode missed");
  property p_aft; frameStrobe && prevBad && !badFrame && !alignContinue && !steadyOut
    && lostFrameCount > 8'h01 && diffEnergy >= `LCMS_THR_SMOOTH
    |=> concealMode == `LCMS_M_AFT_BURST; endproperty
  a_aft: assert property (p_aft) else $error("after-burst mode missed");
  property p_allow; frameStrobe && badFrame |=> $stable(alignAllowed); endproperty
  a_allow: assert property (p_allow) else $error("allow flag moved on loss");
  c_pml: cover property (modeValid && concealMode == `LCMS_M_PM_LOST);
  c_pmb: cover property (modeValid && concealMode == `LCMS_M_PM_BURST);
  c_aft: cover property (modeValid && concealMode == `LCMS_M_AFT_BURST);
endmodule // lcms_monitor

// file: testbench/lcms_dec_model.sv
/*
  Frame decoder stand-in: presents one frame per request.
  Assumes req and rnd change just after the rising edge.
*/
`timescale 1ns/1ps

module lcms_dec_model (
  input  wire         clock,
  input  wire         req,
  input  wire [31:0]  rnd,
  output reg          frameStrobe,
  output reg          badFrame,
  output reg          frameFreqMode,
  output reg  [15:0]  diffEnergy,
  output reg          transientFrame,
  output reg  [127:0] bandNorms
);
  reg [15:0] lvl [0:5];
  // Levels straddle both thresholds
  initial begin
    {lvl[0], lvl[1], lvl[2]} = {16'h0000, 16'h083e, 16'h083f};
    {lvl[3], lvl[4], lvl[5]} = {16'h28b7, 16'h28b8, 16'hffff};
    {frameStrobe, badFrame, frameFreqMode, diffEnergy, transientFrame, bandNorms} = 0;
  end
  // Idle lines toggle so a stale value never passes for a frame
  always @(negedge clock) begin
    frameStrobe <= req;
    if (req) begin
      badFrame       <= rnd[0];
      frameFreqMode  <= rnd[2];
      transientFrame <= &rnd[5:3];
      diffEnergy     <= lvl[rnd[8:6] % 6];
      bandNorms      <= {16{8'h10}} | (128'h80 << (8 * (rnd[11:9] % 6)));
    end else begin
      {badFrame, frameFreqMode, transientFrame} <= ~{badFrame, frameFreqMode, transientFrame};
      diffEnergy <= ~diffEnergy;
      bandNorms  <= ~bandNorms;
    end
  end
endmodule // lcms_dec_model

// file: testbench/tb.sv
/*
  Self-checking bench: random frames against a behavioural model.
  Assumes the design answers one cycle after each taken strobe.
*/
`timescale 1ns/1ps

module tb;
  reg clock = 0, resetn = 0, req = 0;
  reg [31:0] rnd = 32'h2227;
  wire frameStrobe, badFrame, frameFreqMode, transientFrame, modeValid, prevBad;
  wire alignAllowed, alignContinue, steadyOut, fdConceal, spectrumRepeat, overlapAddPrev;
  wire [15:0] diffEnergy;
  wire [127:0] bandNorms;
  wire [7:0] concealMode, lostFrameCount;
  wire [4:0] frameClass;
  int fails = 0, totalChecks = 0, pp;
  logic [7:0] cnt, eM, eK, c;
  bit pb, al, co, so, sOld, lf, eF, pv, sc, st;
  bit thq[$];                  // Transient flags of the last three good frames

  always #2.5 clock = ~clock;
  lcms_dec_model dec_u (
    .clock          (clock),
    .req            (req),
    .rnd            (rnd),
    .frameStrobe    (frameStrobe),
    .badFrame       (badFrame),
    .frameFreqMode  (frameFreqMode),
    .diffEnergy     (diffEnergy),
    .transientFrame (transientFrame),
    .bandNorms      (bandNorms)
  );
  lcms_mode_select dut_u (
    .clock          (clock),
    .resetn         (resetn),
    .frameStrobe    (frameStrobe),
    .badFrame       (badFrame),
    .frameFreqMode  (frameFreqMode),
    .diffEnergy     (diffEnergy),
    .transientFrame (transientFrame),
    .bandNorms      (bandNorms),
    .modeValid      (modeValid),
    .concealMode    (concealMode),
    .frameClass     (frameClass),
    .lostFrameCount (lostFrameCount),
    .prevBad        (prevBad),
    .alignAllowed   (alignAllowed),
    .alignContinue  (alignContinue),
    .steadyOut      (steadyOut),
    .fdConceal      (fdConceal),
    .spectrumRepeat (spectrumRepeat),
    .overlapAddPrev (overlapAddPrev)
  );

  function automatic [31:0] xs(input [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    xs = x ^ (x << 5);
  endfunction

  task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // ----------------------------------------------------------------
  // Reference decision, one call per taken frame
  // ----------------------------------------------------------------
  task mdl;
    int pk;
    begin
      pk = rnd[11:9] % 6;
      c = badFrame ? (pb ? (cnt == 8'hff ? cnt : cnt + 1) : 1) : (pb ? cnt : 0);
      sc = diffEnergy < 16'h083f;
      if (sOld == sc) so = sc;
      sOld = sc;
      st = so | (diffEnergy < 16'h28b8);
      eK = badFrame ? (pb ? 4 : 2) : (pb ? (c > 1 ? 16 : 8) : 1);
      if (badFrame && c == 1 && al && !co) begin eM = 2; co = 1; end
      else if (pb && !badFrame && co) begin eM = 4; co = 0; end
      else if (pb && badFrame && co) eM = 8;
      else if (badFrame) begin eM = st ? 16 : 128; co = 0; end
      else if (pb) begin eM = st ? 32 : (c > 1 ? 64 : 128); co = 0; end
      else eM = 1;
      eF = badFrame & lf;
      // History only moves on good frames, after it has been used
      if (!badFrame) begin
        al = pk >= 1 && pk <= 4 && pk - pp <= 1 && pp - pk <= 1 && sc
          && !(thq[0] | thq[1] | thq[2]);
        pp = pk;
        thq.push_back(transientFrame);
        thq.delete(0);
        lf = frameFreqMode;
      end
      pb = badFrame;
      cnt = c;
    end
  endtask

  task chkall;
    chk("mode", concealMode, eM);
    chk("class", frameClass, eK);
    chk("count", lostFrameCount, cnt);
    chk("prev", prevBad, pb);
    chk("allow", alignAllowed, al);
    chk("cont", alignContinue, co);
    chk("steady", steadyOut, so);
    chk("fd", fdConceal, eF);
    chk("spec", spectrumRepeat, eF);
    chk("ola", overlapAddPrev, eM == 128);
    chk("valid", modeValid, pv);
  endtask

  task fr(input bit g);
    @(posedge clock);
    req = g;
    rnd = xs(rnd);
    @(negedge clock);
    #1;
    chkall;
    if (g) mdl;
    pv = g;
  endtask

  task rst(input int n);
    @(negedge clock);
    resetn = 0;
    req = 0;
    {cnt, pb, al, co, so, sOld, lf, eF, pv, pp} = 0;
    thq = '{1'h0, 1'h0, 1'h0};
    {eM, eK} = {8'h01, 8'h01};
    repeat (n) @(negedge clock);
    chkall;
    resetn = 1;
  endtask

  task stopTest;
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    rst(8);
    repeat (3000) fr(rnd[13:12] != 0);
    // An idle slot lets the last frame's answer be checked before reset
    fr(0);
    $display("test random frames done");
    rst(3);
    repeat (2000) fr(1);
    fr(0);
    $display("test back-to-back frames done");
    stopTest;
  end

  // Full run needs about 5000 cycles
  initial begin
    #60000;
    fails++;
    stopTest;
  end
endmodule // tb

bind lcms_mode_select lcms_monitor mon_u (
  .clock          (clock),
  .resetn         (resetn),
  .frameStrobe    (frameStrobe),
  .badFrame       (badFrame),
  .diffEnergy     (diffEnergy),
  .modeValid      (modeValid),
  .concealMode    (concealMode),
  .frameClass     (frameClass),
  .lostFrameCount (lostFrameCount),
  .prevBad        (prevBad),
  .alignAllowed   (alignAllowed),
  .alignContinue  (alignContinue),
  .steadyOut      (steadyOut),
  .fdConceal      (fdConceal),
  .spectrumRepeat (spectrumRepeat),
  .overlapAddPrev (overlapAddPrev)
);
